// file: uaaf_defs.svh
// constants of the receive address filter
`ifndef UAAF_DEFS_SVH
`define UAAF_DEFS_SVH
`define UAAF_OFF_CTRL 12'h000
`define UAAF_OFF_ADDR 12'h004
`define UAAF_OFF_MASK 12'h008
`define UAAF_OFF_DATA 12'h00c
`define UAAF_OFF_STAT 12'h010
`define UAAF_OFF_IMSK 12'h014
`define UAAF_RST_BYTE 8'h00
`define UAAF_MODE_SHIFT 2'h0
`define UAAF_MODE_8BIT 2'h1
`define UAAF_BAUD_PERIOD_NS 8680
`define UAAF_CLK_PERIOD_NS 40
`define UAAF_BIT_CYCLES ((`UAAF_BAUD_PERIOD_NS) / (`UAAF_CLK_PERIOD_NS))
`define UAAF_HALF_CYCLES ((`UAAF_BIT_CYCLES) / 2)
`define UAAF_CNT_ONE 8'h01
`define UAAF_BITS_8 4'h8
`define UAAF_BITS_9 4'h9
`define UAAF_EV_DONE 0
`define UAAF_EV_FRAME 1
`endif

// file: uaaf_pkg.sv
// types of the receive address filter
package uaaf_pkg;
   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } uaaf_apb_req_type;
   typedef enum logic [3:0] {
      UAAF_IDLE = 4'h1,
      UAAF_START = 4'h2,
      UAAF_BITS = 4'h4,
      UAAF_STOP = 4'h8
   } uaaf_state_type;
endpackage : uaaf_pkg

// file: uaaf_rx_filter.sv
// receive path with automatic address filter and apb registers
// What this block does
// RQ1 - in modes 2 and 3 with compare set, done is raised only for a matching address byte.
// RQ2 - in modes 1 to 3 with compare set, only ninth-bit-one frames are address candidates.
// RQ3 - with compare clear, every data frame with ninth bit zero raises done.
// RQ4 - the master sends ninth bit one for addresses and zero for data.
// RQ5 - in mode 1 with compare set, the stop bit acts as ninth bit and must be valid.
// RQ6 - in mode 0 the compare bit has no effect.
// RQ7 - given match ignores mask-zero positions and compares mask-one positions.
// RQ8 - broadcast is address or mask; its one positions must be received as one.
// RQ9 - address and mask reset to zero so every address matches.
// RQ10 - the master usually broadcasts with an all-ones byte.
// RQ11 - in modes 1 to 3 reception starts on a start bit only while receive enable is set.
// RQ12 - two mode bits in the control register select one of four modes.
// RQ13 - comparison uses the eight data bits only.
// RQ14 - a frame matches on given or broadcast comparison, evaluated in parallel.
`include "uaaf_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module uaaf_rx_filter (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire uaaf_pkg::uaaf_apb_req_type apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxd,
   output logic irq
);
   import uaaf_pkg::*;
   localparam logic [15:0] BIT_CYC = 16'(`UAAF_BIT_CYCLES);
   localparam logic [15:0] HALF_CYC = 16'(`UAAF_HALF_CYCLES);

   // ****************************************
   // registers
   // ****************************************
   logic [1:0] mode_q;
   logic compare_q;
   logic ren_q;
   logic [7:0] node_address_q;
   logic [7:0] node_address_mask_q;
   logic [7:0] rx_data_q;
   logic ninth_q;
   logic [1:0] stat_q;
   logic [1:0] imsk_q;
   logic done_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irq_q;

   // ****************************************
   // apb decode
   // ****************************************
   wire logic setup = apb_req.psel && !apb_req.penable;
   wire logic access = apb_req.psel && apb_req.penable && pready_q;
   wire logic wr = access && apb_req.pwrite;
   wire logic hit_ctrl = apb_req.paddr == `UAAF_OFF_CTRL;
   wire logic hit_addr = apb_req.paddr == `UAAF_OFF_ADDR;
   wire logic hit_mask = apb_req.paddr == `UAAF_OFF_MASK;
   wire logic hit_data = apb_req.paddr == `UAAF_OFF_DATA;
   wire logic hit_stat = apb_req.paddr == `UAAF_OFF_STAT;
   wire logic hit_imsk = apb_req.paddr == `UAAF_OFF_IMSK;
   wire logic hit_any = hit_ctrl || hit_addr || hit_mask || hit_data || hit_stat || hit_imsk;
   logic [31:0] rd_mux;
   always_comb begin
      if (hit_ctrl) begin
         rd_mux = {27'h0, done_q, ren_q, compare_q, mode_q};
      end else if (hit_addr) begin
         rd_mux = {24'h0, node_address_q};
      end else if (hit_mask) begin
         rd_mux = {24'h0, node_address_mask_q};
      end else if (hit_data) begin
         rd_mux = {23'h0, ninth_q, rx_data_q};
      end else if (hit_stat) begin
         rd_mux = {30'h0, stat_q};
      end else if (hit_imsk) begin
         rd_mux = {30'h0, imsk_q};
      end else begin
         rd_mux = 32'h0;
      end
   end

   // ****************************************
   // receiver
   // ****************************************
   uaaf_state_type st_q;
   logic [15:0] cnt_q;
   logic [3:0] nbit_q;
   logic [8:0] shf_q;
   wire logic is_shift = mode_q == `UAAF_MODE_SHIFT;
   wire logic is_8bit = mode_q == `UAAF_MODE_8BIT;
   wire logic [3:0] nbits = is_8bit ? `UAAF_BITS_8 : `UAAF_BITS_9;
   wire logic tick = cnt_q == 16'h0;
   // RQ13 data bits only
   wire logic [7:0] rx_byte = is_8bit ? shf_q[8:1] : shf_q[7:0];
   // RQ5 stop as ninth bit
   wire logic mark_bit = is_8bit ? rxd : shf_q[8];
   // RQ7 given match
   wire logic given_hit = ((rx_byte ^ node_address_q) & node_address_mask_q) == 8'h00;
   // RQ8 broadcast match
   wire logic [7:0] bcast = node_address_q | node_address_mask_q;
   wire logic bcast_hit = (rx_byte & bcast) == bcast;
   // RQ14 either match
   wire logic addr_hit = given_hit || bcast_hit;
   // RQ1 RQ2 RQ3 RQ5 RQ6 done qualification
   wire logic accept = is_shift || !compare_q || (mark_bit && addr_hit);
   wire logic frame_end = st_q == UAAF_STOP && tick;
   wire logic set_done = frame_end && accept;
   wire logic rd_stat = access && !apb_req.pwrite && hit_stat;
   // a read clears only the bits that it reported
   wire logic [1:0] stat_clr = rd_stat ? prdata_q[1:0] : 2'h0;
   logic [1:0] stat_set;
   always_comb begin
      stat_set = 2'h0;
      stat_set[`UAAF_EV_DONE] = set_done;
      stat_set[`UAAF_EV_FRAME] = frame_end;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= UAAF_IDLE;
         cnt_q <= 16'h0;
         nbit_q <= 4'h0;
         shf_q <= 9'h0;
      end else if (ce) begin
         cnt_q <= tick ? BIT_CYC - 16'h1 : cnt_q - 16'h1;
         case (st_q)
            UAAF_IDLE: begin
               // RQ11 start needs enable
               if (ren_q && !rxd) begin
                  st_q <= UAAF_START;
                  cnt_q <= HALF_CYC;
               end
            end
            UAAF_START: begin
               if (tick) begin
                  st_q <= rxd ? UAAF_IDLE : UAAF_BITS;
                  nbit_q <= 4'h0;
               end
            end
            UAAF_BITS: begin
               if (tick) begin
                  shf_q <= {rxd, shf_q[8:1]};
                  nbit_q <= nbit_q + 4'h1;
                  if (nbit_q == nbits - 4'h1) begin
                     st_q <= UAAF_STOP;
                  end
               end
            end
            UAAF_STOP: begin
               if (tick) begin
                  st_q <= UAAF_IDLE;
               end
            end
            default: begin
               st_q <= UAAF_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // register writes and flags
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         // RQ9 reset clears address and mask
         node_address_q <= `UAAF_RST_BYTE;
         node_address_mask_q <= `UAAF_RST_BYTE;
         mode_q <= 2'h0;
         compare_q <= 1'b0;
         ren_q <= 1'b0;
         imsk_q <= 2'h0;
      end else if (ce && wr) begin
         // RQ12 mode select
         if (hit_ctrl) begin
            mode_q <= apb_req.pwdata[1:0];
            compare_q <= apb_req.pwdata[2];
            ren_q <= apb_req.pwdata[3];
         end
         if (hit_addr) begin
            node_address_q <= apb_req.pwdata[7:0];
         end
         if (hit_mask) begin
            node_address_mask_q <= apb_req.pwdata[7:0];
         end
         if (hit_imsk) begin
            imsk_q <= apb_req.pwdata[1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         done_q <= 1'b0;
         rx_data_q <= 8'h00;
         ninth_q <= 1'b0;
         stat_q <= 2'h0;
      end else if (ce) begin
         if (set_done) begin
            done_q <= 1'b1;
            rx_data_q <= rx_byte;
            ninth_q <= mark_bit;
         end else if (wr && hit_ctrl && !apb_req.pwdata[4]) begin
            done_q <= 1'b0;
         end
         stat_q <= stat_set | (stat_q & ~stat_clr);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (ce) begin
         pready_q <= setup;
         pslverr_q <= setup && !hit_any;
         prdata_q <= setup ? rd_mux : 32'h0;
         irq_q <= |(stat_q & imsk_q);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;

   // ****************************************
   // checks
   // ****************************************
   property p_data_reject;
      @(posedge clk) disable iff (rst)
         ce && frame_end && !is_shift && compare_q && !mark_bit
         |=> !done_q || $past(done_q);
   endproperty
   a_data_reject: assert property (p_data_reject) else $error("unmarked frame raised done"); // RQ2

   property p_addr_accept;
      @(posedge clk) disable iff (rst)
         ce && frame_end && compare_q && mark_bit && addr_hit |=> done_q;
   endproperty
   a_addr_accept: assert property (p_addr_accept) else $error("matching address lost"); // RQ1

   property p_free_accept;
      @(posedge clk) disable iff (rst)
         ce && frame_end && !compare_q |=> done_q && rx_data_q == $past(rx_byte);
   endproperty
   a_free_accept: assert property (p_free_accept) else $error("data frame not accepted"); // RQ3

   property p_mode0;
      @(posedge clk) disable iff (rst) ce && frame_end && is_shift |=> done_q;
   endproperty
   a_mode0: assert property (p_mode0) else $error("compare acted in mode 0"); // RQ6

   property p_stop_reject;
      @(posedge clk) disable iff (rst)
         ce && frame_end && is_8bit && compare_q && !rxd
         |=> rx_data_q == $past(rx_data_q) && ninth_q == $past(ninth_q);
   endproperty
   a_stop_reject: assert property (p_stop_reject) else $error("broken stop accepted"); // RQ5

   property p_given;
      @(posedge clk) disable iff (rst)
         ce && frame_end && compare_q && mark_bit
         && (rx_byte & node_address_mask_q) == (node_address_q & node_address_mask_q)
         |=> done_q && rx_data_q == $past(rx_byte);
   endproperty
   a_given: assert property (p_given) else $error("given address not matched"); // RQ7

   property p_bcast;
      @(posedge clk) disable iff (rst)
         ce && frame_end && compare_q && mark_bit
         && (rx_byte | ~(node_address_q | node_address_mask_q)) == 8'hff
         |=> done_q;
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast address not matched"); // RQ8

   property p_reset;
      @(posedge clk) rst |=> node_address_q == 8'h00 && node_address_mask_q == 8'h00;
   endproperty
   a_reset: assert property (p_reset) else $error("address regs not cleared"); // RQ9

   property p_ren;
      @(posedge clk) disable iff (rst) ce && st_q == UAAF_IDLE && !ren_q |=> st_q == UAAF_IDLE;
   endproperty
   a_ren: assert property (p_ren) else $error("reception without enable"); // RQ11

   property p_start;
      @(posedge clk) disable iff (rst)
         ce && st_q == UAAF_IDLE && ren_q && !rxd |=> st_q == UAAF_START;
   endproperty
   a_start: assert property (p_start) else $error("start bit ignored"); // RQ11

   property p_frame_len;
      @(posedge clk) disable iff (rst)
         ce && frame_end |-> nbit_q == (is_8bit ? `UAAF_BITS_8 : `UAAF_BITS_9);
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("wrong bit count for mode"); // RQ12

   property p_either;
      @(posedge clk) disable iff (rst)
         ce && frame_end && !is_shift && compare_q && mark_bit
         && (rx_byte & node_address_mask_q) != (node_address_q & node_address_mask_q)
         && (rx_byte | ~(node_address_q | node_address_mask_q)) != 8'hff
         |=> rx_data_q == $past(rx_data_q) && ninth_q == $past(ninth_q);
   endproperty
   a_either: assert property (p_either) else $error("unmatched address accepted"); // RQ14

   property p_set_wins;
      @(posedge clk) disable iff (rst) ce && set_done |=> stat_q[`UAAF_EV_DONE];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("done event lost"); // RQ3

   c_addr: cover property (@(posedge clk) disable iff (rst) set_done && compare_q);
   c_reject: cover property (@(posedge clk) disable iff (rst) frame_end && !accept);
   c_irq: cover property (@(posedge clk) disable iff (rst) irq);
   c_mode1: cover property (@(posedge clk) disable iff (rst) set_done && is_8bit && compare_q);
   c_bcast: cover property (@(posedge clk) disable iff (rst) set_done && compare_q && !given_hit);
endmodule : uaaf_rx_filter
`default_nettype wire

// file: uaaf_master_model.sv
// master controller model driving the shared serial line
`include "uaaf_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module uaaf_master_model (
   input wire logic clk,
   output logic rxd
);
   initial rxd = 1'b1;
   // ****************
   // frame sender
   // ****************
   // ninth bit marks
   task automatic send(input logic [7:0] b, input logic ninth, input logic nine,
      input logic stop);
      logic [10:0] f;
      int n;
      f = {stop, ninth, b, 1'b0};
      n = nine ? 11 : 10;
      if (!nine) f[9] = stop;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rxd <= f[i];
         repeat (`UAAF_BIT_CYCLES - 1) @(posedge clk);
      end
      @(posedge clk);
      rxd <= 1'b1;
   endtask : send
endmodule : uaaf_master_model
`default_nettype wire

// file: testbench.sv
// self-checking bench of the receive address filter
`include "uaaf_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import uaaf_pkg::*;
   logic clk, rst, ce, rxd, pready, pslverr, irq, last_err;
   logic [31:0] prdata, rdata;
   uaaf_apb_req_type req;
   int failures = 0;
   int checked = 0;
   uaaf_rx_filter u_uaaf_rx_filter (.clk(clk), .rst(rst), .ce(ce), .apb_req(req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .irq(irq));
   uaaf_master_model u_uaaf_master_model (.clk(clk), .rxd(rxd));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdata = prdata;
      last_err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string s);
      apb(1'b0, a, 32'h0);
      chk(s, e, rdata);
   endtask : rd
   task automatic frame(input logic [7:0] b, input logic ninth, input logic nine,
      input logic stop, input logic e);
      u_uaaf_master_model.send(b, ninth, nine, stop);
      apb(1'b0, `UAAF_OFF_STAT, 32'h0);
      chk("done", {31'h0, e}, {31'h0, rdata[0]});
   endtask : frame
   task automatic t_reset;
      rd(`UAAF_OFF_ADDR, 32'h0, "addr");
      rd(`UAAF_OFF_MASK, 32'h0, "mask");
      rd(12'h018, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, last_err});
      apb(1'b1, `UAAF_OFF_CTRL, 32'h0f);
      frame(8'h37, 1'b1, 1'b1, 1'b1, 1'b1);
      $display("test reset done");
   endtask : t_reset
   task automatic t_filter;
      logic [8:0] v [5] = '{9'h1f4, 9'h1f3, 9'h1ff, 9'h0f4, 9'h174};
      logic [4:0] e = 5'b00101;
      apb(1'b1, `UAAF_OFF_ADDR, 32'hf1);
      apb(1'b1, `UAAF_OFF_MASK, 32'hfa);
      for (int m = 2; m < 4; m++) begin
         apb(1'b1, `UAAF_OFF_CTRL, 32'hc | m);
         for (int i = 0; i < 5; i++) begin
            frame(v[i][7:0], v[i][8], 1'b1, 1'b1, e[i]);
         end
      end
      $display("test filter done");
   endtask : t_filter
   task automatic t_modes;
      apb(1'b1, `UAAF_OFF_CTRL, 32'h0b);
      u_uaaf_master_model.send(8'h5a, 1'b0, 1'b1, 1'b1);
      rd(`UAAF_OFF_CTRL, 32'h1b, "done flag");
      rd(`UAAF_OFF_DATA, 32'h05a, "data");
      rd(`UAAF_OFF_STAT, 32'h3, "status");
      apb(1'b1, `UAAF_OFF_CTRL, 32'h0d);
      rd(`UAAF_OFF_CTRL, 32'h0d, "done cleared");
      frame(8'hf4, 1'b0, 1'b0, 1'b1, 1'b1);
      frame(8'hf4, 1'b0, 1'b0, 1'b0, 1'b0);
      frame(8'hf3, 1'b0, 1'b0, 1'b1, 1'b0);
      apb(1'b1, `UAAF_OFF_CTRL, 32'h0c);
      frame(8'h00, 1'b0, 1'b1, 1'b1, 1'b1);
      $display("test modes done");
   endtask : t_modes
   task automatic t_irq;
      apb(1'b1, `UAAF_OFF_CTRL, 32'h03);
      u_uaaf_master_model.send(8'h11, 1'b0, 1'b1, 1'b1);
      rd(`UAAF_OFF_STAT, 32'h0, "rx off");
      apb(1'b1, `UAAF_OFF_CTRL, 32'h0b);
      apb(1'b1, `UAAF_OFF_IMSK, 32'h1);
      u_uaaf_master_model.send(8'h22, 1'b0, 1'b1, 1'b1);
      chk("irq set", 32'h1, {31'h0, irq});
      rd(`UAAF_OFF_STAT, 32'h3, "status");
      repeat (3) @(posedge clk);
      chk("irq clear", 32'h0, {31'h0, irq});
      apb(1'b1, `UAAF_OFF_IMSK, 32'h0);
      u_uaaf_master_model.send(8'h33, 1'b0, 1'b1, 1'b1);
      chk("irq masked", 32'h0, {31'h0, irq});
      rd(`UAAF_OFF_STAT, 32'h3, "status");
      $display("test irq done");
   endtask : t_irq
   task automatic t_freeze;
      @(posedge clk);
      ce <= 1'b0;
      u_uaaf_master_model.send(8'h44, 1'b0, 1'b1, 1'b1);
      @(posedge clk);
      ce <= 1'b1;
      rd(`UAAF_OFF_STAT, 32'h0, "frozen");
      $display("test freeze done");
   endtask : t_freeze
   task automatic complete_run;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   initial begin
      req = '0;
      ce = 1'b1;
      rst = 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_filter();
      t_modes();
      t_irq();
      t_freeze();
      complete_run();
   end
   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      complete_run();
   end
endmodule : testbench
`default_nettype wire
